// [verilog/psl_params.svh]
`ifndef PSL_PARAMS_SVH
`define PSL_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PSL_CLK_PERIOD_NS   100
`define PSL_RST_MIN_NS      1000
`define PSL_RST_MIN_CYC     ((`PSL_RST_MIN_NS + `PSL_CLK_PERIOD_NS - 1) / `PSL_CLK_PERIOD_NS)
`define PSL_INIT_NS         200000
`define PSL_INIT_CYC        (`PSL_INIT_NS / `PSL_CLK_PERIOD_NS)
`define PSL_BLINK_NS        50000000
`define PSL_BLINK_CYC       (`PSL_BLINK_NS / `PSL_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PSL_ADDR_W          5
`define PSL_DATA_W          16
`define PSL_REG_STATUS      5'h10
`define PSL_REG_MULTI_IND   5'h18
`define PSL_REG_PHY_CONTROL 5'h19

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PSL_PC_AN_EN        15
`define PSL_PC_SPEED100     14
`define PSL_PC_XOVER        13
`define PSL_PC_IND_MODE     5
`define PSL_MI_COL_OFF      0
`define PSL_MI_ACT_COL      1
`define PSL_ST_LINK         9
`define PSL_ST_READY        10
`define PSL_MI_RESET        2'h0
`define PSL_ADDR_DEFAULT    5'h01

`endif

// [verilog/psl_pkg.sv]
package psl_pkg;

   // Values captured from the strap pins while reset is low
   typedef struct packed {
      logic       rmii;
      logic       xover;
      logic       ind_mode;
      logic       duplex;
      logic [4:0] addr;
   } psl_strap_s;

   // One receive nibble on its way to the MAC
   typedef struct packed {
      logic [3:0] data;
   } psl_nibble_s;

   typedef logic [3:0] psl_advert_t;

   typedef enum logic {
      PSL_INIT,
      PSL_RUN
   } psl_state_e;

endpackage

// [verilog/psl_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Two-stage synchroniser, no reset: pure data path
// ----------------------------------------------------------------------
module psl_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      meta <= d;
      q    <= meta;
   end
endmodule // psl_sync

`default_nettype wire

// [verilog/psl_buf.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Small valid/ready buffer, two entries by default
// ----------------------------------------------------------------------
module psl_buf #(
   parameter int unsigned W     = 4,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output var  logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output var  logic         out_valid,
   input  wire logic         out_ready,
   output var  logic [W-1:0] out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointer wrap relies on a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("psl_buf: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;

   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;

   // Honest full and empty from the fill count
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
         rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
         count  <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // psl_buf

`default_nettype wire

// [verilog/psl_core.sv]
`include "psl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module psl_core #(
   parameter int unsigned INIT_CYC  = `PSL_INIT_CYC,
   parameter int unsigned BLINK_CYC = `PSL_BLINK_CYC
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic [`PSL_ADDR_W-1:0]  reg_addr,
   input  wire logic [`PSL_DATA_W-1:0]  reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output var  logic [`PSL_DATA_W-1:0]  reg_rdata,
   input  wire logic                    link_clk,
   input  wire logic                    mac_tx_en,
   input  wire logic [3:0]              mac_txd,
   input  wire logic                    mac_rx_ready,
   input  wire logic [3:0]              rxd_i,
   output var  logic [3:0]              rxd_o,
   output var  logic [3:0]              rxd_oe,
   input  wire logic                    rx_dv_i,
   output var  logic                    rx_dv_o,
   output var  logic                    rx_dv_oe,
   input  wire logic                    rx_er_i,
   output var  logic                    rx_er_o,
   output var  logic                    rx_er_oe,
   input  wire logic                    col_i,
   output var  logic                    col_o,
   output var  logic                    col_oe,
   input  wire logic                    crs_i,
   output var  logic                    crs_o,
   output var  logic                    crs_oe,
   input  wire logic                    link_indicator_i,
   output var  logic                    link_indicator_o,
   output var  logic                    link_indicator_oe,
   input  wire logic [3:0]              line_rxd,
   input  wire logic                    line_rx_dv,
   input  wire logic                    line_link_up,
   output var  logic                    line_rx_ready,
   output var  logic [3:0]              line_txd,
   output var  logic                    line_tx_en,
   output var  logic                    phy_ready,
   output var  psl_pkg::psl_advert_t    advert,
   output var  logic                    auto_crossover,
   output var  logic                    rmii_mode
);
   if (INIT_CYC < 1 || INIT_CYC > 65535 || BLINK_CYC < 1) begin : g_bad_param
      $error("psl_core: counts out of range");
   end

   // ------------------------------------------------------------------
   // Synchronisers for every pin input except mac_rx_ready
   // ------------------------------------------------------------------
   logic [8:0] strap_pins;
   logic [11:0] link_pins;

   psl_sync #(.W(9)) u_sync_strap (
      .clk (clk),
      .d   ({rx_dv_i, rx_er_i, crs_i, link_indicator_i, rxd_i, col_i}),
      .q   (strap_pins)
   );

   psl_sync #(.W(12)) u_sync_link (
      .clk (clk),
      .d   ({link_clk, mac_tx_en, mac_txd, line_rxd, line_rx_dv, line_link_up}),
      .q   (link_pins)
   );

   // ------------------------------------------------------------------
   // Decode of synchronised pins
   // ------------------------------------------------------------------
   psl_pkg::psl_strap_s pin_strap;
   psl_pkg::psl_strap_s strap;
   logic                link_clk_q;

   assign pin_strap = psl_pkg::psl_strap_s'(strap_pins);
   wire       link_clk_s = link_pins[11];
   wire       tx_en_s    = link_pins[10];
   wire [3:0] txd_s      = link_pins[9:6];
   wire [3:0] rxd_line_s = link_pins[5:2];
   wire       rx_dv_s    = link_pins[1];
   wire       link_up_s  = link_pins[0];
   wire       link_rise  = link_clk_s && !link_clk_q;

   // ------------------------------------------------------------------
   // Strap capture and internal reset sequencing
   // ------------------------------------------------------------------
   psl_pkg::psl_state_e state;
   logic [15:0]         init_cnt;

   // Straps follow the pins only while reset is low; the pins carry the
   // weak pull levels then because every output enable is off
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strap <= pin_strap;
      end
   end

   // Internal reset completes a fixed time after release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state    <= psl_pkg::PSL_INIT;
         init_cnt <= '0;
      end else if (state == psl_pkg::PSL_INIT) begin
         init_cnt <= init_cnt + 16'h0001;
         if (init_cnt == 16'(INIT_CYC - 1)) begin
            state <= psl_pkg::PSL_RUN;
         end
      end
   end

   wire run = (state == psl_pkg::PSL_RUN);

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   logic [`PSL_DATA_W-1:0] phy_control;
   logic [1:0]             multi_indicator_control;

   wire sel_pc = (reg_addr == `PSL_REG_PHY_CONTROL);
   wire sel_mi = (reg_addr == `PSL_REG_MULTI_IND);
   wire sel_st = (reg_addr == `PSL_REG_STATUS);

   wire [`PSL_DATA_W-1:0] status_word = {5'h00, run, link_up_s, strap.rmii, strap.xover,
                                         strap.ind_mode, strap.duplex, strap.addr};
   wire [`PSL_DATA_W-1:0] rd_mux = sel_pc ? phy_control :
                                   sel_mi ? {14'h0000, multi_indicator_control} :
                                   sel_st ? status_word : 16'h0000;

   // Control register reloads defaults and strap-derived bits at reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phy_control                    <= 16'h0000;
         phy_control[`PSL_PC_AN_EN]     <= 1'b1;
         phy_control[`PSL_PC_SPEED100]  <= 1'b1;
         phy_control[`PSL_PC_XOVER]     <= pin_strap.xover;
         phy_control[`PSL_PC_IND_MODE]  <= pin_strap.ind_mode;
      end else if (reg_wr && sel_pc) begin
         phy_control <= reg_wdata;
      end
   end

   // Multi-indicator routing, and read data for exactly one cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         multi_indicator_control <= `PSL_MI_RESET;
         reg_rdata               <= 16'h0000;
      end else begin
         if (reg_wr && sel_mi) begin
            multi_indicator_control <= reg_wdata[1:0];
         end
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   wire ind_mode = phy_control[`PSL_PC_IND_MODE];
   wire col_off  = multi_indicator_control[`PSL_MI_COL_OFF];
   wire act_col  = col_off && multi_indicator_control[`PSL_MI_ACT_COL];
   wire half     = !strap.duplex;

   assign advert         = strap.duplex ? 4'hF : 4'h5;  // {100FD,100HD,10FD,10HD}
   assign auto_crossover = phy_control[`PSL_PC_XOVER];
   assign rmii_mode      = strap.rmii;
   assign phy_ready      = run;

   // ------------------------------------------------------------------
   // Data path: transmit nibbles out, received nibbles through buffer
   // ------------------------------------------------------------------
   psl_pkg::psl_nibble_s buf_out;
   logic                 buf_valid;
   wire                  push_rx = link_rise && run && rx_dv_s;
   wire                  pop_rx  = buf_valid && mac_rx_ready;

   psl_buf #(.W(4), .DEPTH(2)) u_rx_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push_rx),
      .in_ready  (line_rx_ready),
      .in_data   (rxd_line_s),
      .out_valid (buf_valid),
      .out_ready (mac_rx_ready),
      .out_data  (buf_out)
   );

   // Transmit nibble taken on each rising reference edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Follow the pin level so a high clock at release is not a false rise
         link_clk_q <= link_clk_s;
         line_txd   <= 4'h0;
         line_tx_en <= 1'b0;
      end else begin
         link_clk_q <= link_clk_s;
         if (link_rise) begin
            line_tx_en <= run && tx_en_s;
            line_txd   <= txd_s;
         end
      end
   end

   // ------------------------------------------------------------------
   // Indicators: blink timer runs only while there is traffic
   // ------------------------------------------------------------------
   logic        blink;
   logic [31:0] blink_cnt;
   wire         activity = tx_en_s || rx_dv_s;
   wire         link_on  = link_up_s && (ind_mode || !activity || blink);

   always_ff @(posedge clk) begin
      if (!rst_n || !activity) begin
         blink     <= 1'b1;
         blink_cnt <= 32'h0000_0000;
      end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
         blink     <= !blink;
         blink_cnt <= 32'h0000_0000;
      end else begin
         blink_cnt <= blink_cnt + 32'h0000_0001;
      end
   end

   // Pin outputs: all released together on the first edge after reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxd_oe            <= 4'h0;
         rx_dv_oe          <= 1'b0;
         rx_er_oe          <= 1'b0;
         col_oe            <= 1'b0;
         crs_oe            <= 1'b0;
         link_indicator_oe <= 1'b0;
         rxd_o             <= 4'h0;
         rx_dv_o           <= 1'b0;
         rx_er_o           <= 1'b0;
         col_o             <= 1'b0;
         crs_o             <= 1'b0;
         link_indicator_o  <= 1'b0;
      end else begin
         rxd_oe            <= 4'hF;
         rx_dv_oe          <= 1'b1;
         rx_er_oe          <= 1'b1;
         col_oe            <= 1'b1;
         crs_oe            <= 1'b1;
         link_indicator_oe <= 1'b1;
         rxd_o             <= pop_rx ? buf_out.data : rxd_o;
         rx_dv_o           <= pop_rx;
         rx_er_o           <= 1'b0;
         crs_o             <= rx_dv_s || (half && tx_en_s);
         // Lit level is the opposite of the pin's strap pull
         link_indicator_o  <= link_on ^ strap.duplex;
         col_o             <= act_col ? ((activity && link_up_s) ^ strap.addr[0]) :
                              col_off ? 1'b0 :
                              (half && tx_en_s && rx_dv_s);
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [15:0] since_rel;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         since_rel <= '0;
      end else if (since_rel != 16'hFFFF) begin
         since_rel <= since_rel + 16'h0001;
      end
   end

   sequence s_release;
      !rst_n ##1 rst_n;
   endsequence

   sequence s_both_ways;
      half && tx_en_s && rx_dv_s && !col_off;
   endsequence

   chk_col_half_dup: assert property (s_both_ways |=> col_o)
      else $error("collision not flagged");
   chk_crs_receive: assert property (rx_dv_s |=> crs_o)
      else $error("carrier missing on receive");
   chk_crs_full_tx: assert property (!half && tx_en_s && !rx_dv_s |=> !crs_o)
      else $error("carrier on own transmit in full duplex");
   chk_strap_stable: assert property ($past(rst_n) |-> $stable(strap))
      else $error("strap changed after reset");
   chk_pins_released: assert property (disable iff (1'b0)
      s_release |=> rxd_oe == 4'hF && rx_dv_oe && col_oe && crs_oe)
      else $error("pins not released after reset");
   chk_pins_hiz: assert property (disable iff (1'b0) !rst_n |=> !rx_dv_oe && !col_oe)
      else $error("pin driven during reset");
   chk_ready_time: assert property (phy_ready == (since_rel >= 16'(INIT_CYC)))
      else $error("ready at wrong time");
   chk_link_steady: assert property (ind_mode && !link_up_s |=> link_indicator_o == strap.duplex)
      else $error("indicator lit without link");
   chk_link_polar: assert property (link_up_s && ind_mode |=> link_indicator_o != strap.duplex)
      else $error("indicator level wrong for link");
   chk_sw_mode: assert property (reg_wr && sel_pc |=> ind_mode == $past(reg_wdata[5]))
      else $error("mode override not taken");
   chk_addr_read: assert property (reg_rd && sel_st |=> reg_rdata[4:0] == strap.addr)
      else $error("address strap readback wrong");
   chk_act_col: assert property (act_col && !activity |=> col_o == strap.addr[0])
      else $error("activity pin level wrong");
   chk_rx_deliver: assert property (pop_rx |=> rx_dv_o && rxd_o == $past(buf_out.data))
      else $error("nibble not delivered");

endmodule // psl_core

`default_nettype wire

// [testbench/psl_mac_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// MAC on the far side of the nibble interface
// ----------------------------------------------------------------------
module psl_mac_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       link_clk,
   input  wire logic [3:0] rxd,
   input  wire logic       rx_dv,
   input  wire logic       stall,
   output var  logic       rx_ready,
   output var  logic       tx_en,
   output var  logic [3:0] txd
);
   logic [3:0] rx_q[$];
   logic [3:0] tx_q[$];
   logic       run = 1'b0;

   // Quiet at time zero
   initial begin
      rx_ready = 1'b1;
      tx_en = 1'b0;
      txd = 4'h0;
   end

   // Collect nibbles; run lags reset so strap levels never pass for data
   always @(posedge clk) begin
      run <= rst_n;
      rx_ready <= !stall;
      if (run && rx_dv === 1'b1) begin
         rx_q.push_back(rxd);
      end
   end

   // One nibble per reference period; released data toggles, never holds
   always @(posedge link_clk) begin
      @(posedge clk);
      if (tx_q.size() > 0) begin
         tx_en <= 1'b1;
         txd <= tx_q.pop_front();
      end else begin
         tx_en <= 1'b0;
         txd <= ~txd;
      end
   end
endmodule // psl_mac_model

`default_nettype wire

// [testbench/testbench.sv]
`include "psl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int unsigned INIT = 20;
   logic                 clk = 1'b0, rst_n = 1'b0, link_clk = 1'b0, stall = 1'b0;
   logic [4:0]           reg_addr = 5'h00;
   logic [15:0]          reg_wdata = 16'h0000, reg_rdata;
   logic                 reg_wr = 1'b0, reg_rd = 1'b0;
   logic                 mac_tx_en, mac_rx_ready, line_rx_dv = 1'b0, line_link_up = 1'b0;
   logic [3:0]           mac_txd, line_rxd = 4'h0, line_txd, advert;
   logic [3:0]           rxd_i, rxd_o, rxd_oe;
   logic                 rx_dv_i, rx_dv_o, rx_dv_oe, rx_er_i, rx_er_o, rx_er_oe;
   logic                 col_i, col_o, col_oe, crs_i, crs_o, crs_oe;
   logic                 link_indicator_i, link_indicator_o, link_indicator_oe;
   logic                 line_rx_ready, line_tx_en, phy_ready, auto_crossover, rmii_mode;
   psl_pkg::psl_strap_s  strap = 9'h0E1;
   psl_pkg::psl_strap_s  tbl[4] = '{9'h0E1, 9'h11E, 9'h0A0, 9'h15F};
   logic [3:0]           tx_list[5] = '{4'h3, 4'hC, 4'hA, 4'h6, 4'h1};
   logic [3:0]           rx_list[4] = '{4'h5, 4'hE, 4'h0, 4'hF};
   logic [3:0]           tx_seen[$];
   logic                 col_seen = 1'b0, crs_seen = 1'b0, ind_prev = 1'b0;
   int                   flips = 0, err_total = 0, compares = 0;

   // ----------------------------------------------------------------------
   // Clocks, pins and instances
   // ----------------------------------------------------------------------
   always #50 clk = ~clk;
   // Reference clock, phase unrelated to clk
   initial begin
      #137;
      forever #400 link_clk = ~link_clk;
   end

   // Pin level: driven value while enabled, else the strap pull
   assign rxd_i = (rxd_oe & rxd_o) | (~rxd_oe & strap.addr[4:1]);
   assign col_i = col_oe ? col_o : strap.addr[0];
   assign rx_dv_i = rx_dv_oe ? rx_dv_o : strap.rmii;
   assign rx_er_i = rx_er_oe ? rx_er_o : strap.xover;
   assign crs_i = crs_oe ? crs_o : strap.ind_mode;
   assign link_indicator_i = link_indicator_oe ? link_indicator_o : strap.duplex;

   psl_core #(.INIT_CYC(INIT), .BLINK_CYC(4)) psl_core_inst (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
      .mac_tx_en(mac_tx_en), .mac_txd(mac_txd), .mac_rx_ready(mac_rx_ready),
      .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .rx_dv_i(rx_dv_i),
      .rx_dv_o(rx_dv_o), .rx_dv_oe(rx_dv_oe), .rx_er_i(rx_er_i), .rx_er_o(rx_er_o),
      .rx_er_oe(rx_er_oe), .col_i(col_i), .col_o(col_o), .col_oe(col_oe),
      .crs_i(crs_i), .crs_o(crs_o), .crs_oe(crs_oe), .link_indicator_i(link_indicator_i),
      .link_indicator_o(link_indicator_o), .link_indicator_oe(link_indicator_oe),
      .line_rxd(line_rxd), .line_rx_dv(line_rx_dv), .line_link_up(line_link_up),
      .line_rx_ready(line_rx_ready), .line_txd(line_txd), .line_tx_en(line_tx_en),
      .phy_ready(phy_ready), .advert(advert), .auto_crossover(auto_crossover),
      .rmii_mode(rmii_mode));

   psl_mac_model mac_inst (
      .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .rxd(rxd_i), .rx_dv(rx_dv_i),
      .stall(stall), .rx_ready(mac_rx_ready), .tx_en(mac_tx_en), .txd(mac_txd));

   // Sticky status flags and indicator edges; cleared by scenarios off-edge
   always @(posedge clk) begin
      if (rst_n) begin
         col_seen = col_seen | (col_o === 1'b1);
         crs_seen = crs_seen | (crs_o === 1'b1);
         if (link_indicator_o !== ind_prev) flips++;
         ind_prev = link_indicator_o;
      end
   end

   // Network transmit nibbles, taken while they stand
   always @(posedge link_clk) begin
      if (line_tx_en === 1'b1) tx_seen.push_back(line_txd);
   end

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask

   task automatic clear_flags();
      @(negedge clk);
      col_seen = 1'b0;
      crs_seen = 1'b0;
      flips = 0;
      tx_seen.delete();
   endtask

   // Reset with given straps; pulls change afterwards, which must not matter
   task automatic do_reset(input psl_pkg::psl_strap_s s);
      int n;
      @(posedge clk);
      rst_n <= 1'b0;
      strap <= s;
      repeat (10) @(posedge clk);
      check({rxd_oe, rx_dv_oe, rx_er_oe, col_oe, crs_oe, link_indicator_oe}, 16'h0);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      check({rxd_oe, rx_dv_oe, rx_er_oe, col_oe, crs_oe, link_indicator_oe}, 16'h1FF);
      strap <= ~s;
      repeat (INIT - 3) @(posedge clk);
      check(phy_ready, 1'b0);
      for (n = 0; n < 8 && phy_ready !== 1'b1; n++) @(posedge clk);
      check(phy_ready, 1'b1);
   endtask

   // Present nibbles in the low phase; a refused one is held and offered again
   task automatic send_rx();
      int i;
      i = 0;
      while (i < 4) begin
         @(negedge link_clk);
         @(posedge clk);
         line_rx_dv <= 1'b1;
         line_rxd <= rx_list[i];
         @(posedge link_clk);
         if (line_rx_ready === 1'b1) i++;
      end
      @(negedge link_clk);
      @(posedge clk);
      line_rx_dv <= 1'b0;
      line_rxd <= ~line_rxd;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_straps(input psl_pkg::psl_strap_s s);
      logic [15:0] d;
      do_reset(s);
      rd(`PSL_REG_STATUS, d);
      check(d, {5'h0, 2'b10, s.rmii, s.xover, s.ind_mode, s.duplex, s.addr});
      rd(`PSL_REG_PHY_CONTROL, d);
      check(d, {2'b11, s.xover, 7'h0, s.ind_mode, 5'h0});
      check(advert, s.duplex ? 4'hF : 4'h5);
      check(auto_crossover, s.xover);
      check(rmii_mode, s.rmii);
   endtask

   task automatic t_regs(input psl_pkg::psl_strap_s s);
      logic [15:0] d;
      wr(`PSL_REG_PHY_CONTROL, 16'h0000);
      rd(`PSL_REG_PHY_CONTROL, d);
      check(d, 16'h0000);
      check(auto_crossover, 1'b0);
      wr(`PSL_REG_PHY_CONTROL, 16'hFFFF);
      rd(`PSL_REG_PHY_CONTROL, d);
      check(d, 16'hFFFF);
      check(auto_crossover, 1'b1);
      wr(`PSL_REG_STATUS, 16'h0000);
      rd(`PSL_REG_STATUS, d);
      check(d[8:0], s);
      rd(5'h03, d);
      check(d, 16'h0000);
      @(posedge clk);
      check(reg_rdata, 16'h0000);
   endtask

   // Transmit alone, then receive through a stalled MAC while transmitting
   task automatic t_traffic(input logic half, input logic mode, input logic [1:0] mi);
      psl_pkg::psl_strap_s s;
      int i;
      s = {3'b011, !half, 5'h01};
      do_reset(s);
      wr(`PSL_REG_PHY_CONTROL, {3'b111, 7'h00, mode, 5'h00});
      wr(`PSL_REG_MULTI_IND, {14'h0, mi});
      @(posedge clk);
      line_link_up <= 1'b1;
      repeat (8) @(posedge clk);
      clear_flags();
      for (i = 0; i < 3; i++) mac_inst.tx_q.push_back(tx_list[i]);
      repeat (48) @(posedge clk);
      check(tx_seen.size(), 3);
      for (i = 0; i < 3; i++) check(tx_seen[i], tx_list[i]);
      check(crs_seen, half);
      clear_flags();
      for (i = 0; i < 5; i++) mac_inst.tx_q.push_back(tx_list[i]);
      stall = 1'b1;
      fork
         send_rx();
         begin
            repeat (5) @(posedge link_clk);
            check(line_rx_ready, 1'b0);
            check(mac_inst.rx_q.size(), 0);
            @(negedge link_clk);
            @(posedge clk);
            stall <= 1'b0;
         end
      join
      repeat (24) @(posedge clk);
      check(mac_inst.rx_q.size(), 4);
      for (i = 0; i < 4; i++) check(mac_inst.rx_q[i], rx_list[i]);
      mac_inst.rx_q.delete();
      check(crs_seen, 1'b1);
      check(col_seen, (half && mi == 2'h0) || mi == 2'h3);
      check(flips != 0, !mode);
      if (mode) check(link_indicator_o, !s.duplex);
      @(posedge clk);
      line_link_up <= 1'b0;
      repeat (8) @(posedge clk);
      check(link_indicator_o, s.duplex);
      check({rx_er_o, col_o}, {1'b0, mi == 2'h3});
   endtask

   task automatic results();
      if (err_total == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      for (int k = 0; k < 4; k++) t_straps(tbl[k]);
      t_regs(tbl[3]);
      t_traffic(1'b1, 1'b1, 2'h0);
      t_traffic(1'b1, 1'b0, 2'h1);
      t_traffic(1'b0, 1'b1, 2'h0);
      t_traffic(1'b0, 1'b0, 2'h0);
      t_traffic(1'b0, 1'b1, 2'h3);
      results();
   end

   // Watchdog, far beyond the roughly one thousand cycles the run needs
   initial begin
      #3000000;
      err_total++;
      results();
   end
endmodule // testbench

`default_nettype wire
